//--- design/dsk_consts.vh
// constants for the diskette command sequencer
`ifndef DSK_CONSTS_VH
`define DSK_CONSTS_VH
`define OP_MASK        8'h1f
`define OP_WRITE       8'h05
`define OP_WRITE_DEL   8'h09
`define OP_FORMAT      8'h0d
`define OP_RECAL       8'h07
`define OP_SENSE_INT   8'h08
`define OP_SPECIFY     8'h03
`define OP_SEEK        8'h0f
`define OP_CONFIGURE   8'h13
`define INVALID_ST0    8'h80
`define NPAR_WRITE     4'h8
`define NPAR_FORMAT    4'h5
`define NPAR_RECAL     4'h1
`define NPAR_SPECIFY   4'h2
`define NPAR_SEEK      4'h2
`define NPAR_CONFIGURE 4'h3
`define NRES_WRITE     3'h7
`define NRES_SENSE     3'h2
`define NRES_INVALID   3'h1
`define P_DRV          0
`define P_CYL          1
`define P_HEAD         2
`define P_SEC          3
`define P_SIZE         4
`define P_EOT          5
`define P_FSC          2
`define P_SPEC0        0
`define P_CFG1         1
`define ST0_SEEK_END   8'h20
`define STEP_NS        3000
`define STEP_CYC       16'd300
`define SEC_BYTES      9'h080
`define IRQ_OFS        4'h0
`define MASK_OFS       4'h1
`define DATA_OFS       4'h2
`define MSR_OFS        4'h3
`define PCN_OFS        4'h4
`define CFG_OFS        4'h5
`endif

//--- design/step_pulser.v
// head step pulse generator, one step every period + 1 clocks
`timescale 1ns/1ps
module step_pulser (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        go,
  input  wire [15:0] period,
  output reg         step_pulse
);
  reg [15:0] cnt_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg    <= 16'h0000;
      step_pulse <= 1'b0;
    end else if (!go) begin
      cnt_reg    <= 16'h0000;
      step_pulse <= 1'b0;
    end else if (cnt_reg >= period) begin
      cnt_reg    <= 16'h0000;
      step_pulse <= 1'b1;
    end else begin
      cnt_reg    <= cnt_reg + 16'h0001;
      step_pulse <= 1'b0;
    end
  end
endmodule // step_pulser

//--- design/diskette_command_sequencer.v
// diskette command, execution and result phase sequencer
// How it works
// (RULE1) write and write-deleted take opcode, drive, cylinder, head, sector, size, eot, gap, dtl.
// (RULE2) during write execution host data bytes are passed one by one to the drive.
// (RULE3) a write ends with seven result bytes: three status, cylinder, head, sector, size.
// (RULE4) recalibrate steps the head out to track 0, raises an interrupt, has no results.
// (RULE5) seek takes drive and target cylinder and steps until the head is there.
// (RULE6) sense interrupt status returns status byte zero then the present cylinder.
// (RULE7) software sends sense interrupt status after each seek or recalibrate interrupt.
// (RULE8) format takes size, sectors, gap, filler, then four id bytes per sector; 7 results.
// (RULE9) an unknown opcode does nothing and returns one result byte of 80h.
`timescale 1ns/1ps
`include "dsk_consts.vh"
module diskette_command_sequencer (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  output wire       irq,
  input  wire       track0,
  input  wire       drive_ready,
  output reg        step,
  output reg        step_dir,
  output reg  [1:0] drive_sel,
  output reg        head_sel,
  output reg  [7:0] wr_byte,
  output reg        wr_byte_valid,
  output wire       write_gate
);
  localparam S_IDLE = 3'd0, S_PARAM = 3'd1, S_DATA = 3'd2, S_FMT = 3'd3,
             S_STEP = 3'd4, S_RES = 3'd5;
  reg [1:0] rsync;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) rsync <= 2'b00;
    else rsync <= {rsync[0], 1'b1};
  end
  wire rst_n = rsync[1];
  ////////////////////////////////////////////////////////////////////////////////
  reg [2:0] state_reg;
  reg [7:0] op_reg;
  reg [3:0] npar_reg, pcnt_reg;
  reg [7:0] par_reg [0:7];
  reg [2:0] nres_reg, rcnt_reg;
  reg [8:0] bcnt_reg;
  reg [7:0] sec_left_reg;
  reg [1:0] fid_reg;
  reg [7:0] pcn_reg, ncn_reg, st0_reg, spec_reg, cfg_reg;
  reg       recal_reg, seek_pend_reg;
  reg [1:0] irq_stat_reg, irq_mask_reg;
  reg       done_evt;
  wire      step_tick;
  function [3:0] par_count;
    input [7:0] op;
    begin
      case (op & `OP_MASK)
        `OP_WRITE, `OP_WRITE_DEL: par_count = `NPAR_WRITE;
        `OP_FORMAT:               par_count = `NPAR_FORMAT;
        `OP_RECAL:                par_count = `NPAR_RECAL;
        `OP_SPECIFY:              par_count = `NPAR_SPECIFY;
        `OP_SEEK:                 par_count = `NPAR_SEEK;
        `OP_CONFIGURE:            par_count = `NPAR_CONFIGURE;
        default:                  par_count = 4'h0;
      endcase
    end
  endfunction
  function is_op;
    input [7:0] op;
    input [7:0] code;
    begin
      is_op = ((op & `OP_MASK) == code);
    end
  endfunction
  wire data_wr = wr && (addr == `DATA_OFS);
  wire data_rd = rd && (addr == `DATA_OFS);
  wire is_write = is_op(op_reg, `OP_WRITE) || is_op(op_reg, `OP_WRITE_DEL);
  assign write_gate = (state_reg == S_DATA) || (state_reg == S_FMT);
  step_pulser step_pulser_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .go         (state_reg == S_STEP),
    .period     (`STEP_CYC),
    .step_pulse (step_tick)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // result byte selection
  reg [7:0] res_byte;
  always @* begin
    res_byte = 8'h00;
    if (is_op(op_reg, `OP_SENSE_INT)) begin
      res_byte = (rcnt_reg == 3'd0) ? st0_reg : pcn_reg; // RULE6
    end else if (is_write) begin
      case (rcnt_reg) // RULE3
        3'd0:    res_byte = {5'h00, par_reg[`P_DRV][2:0]};
        3'd3:    res_byte = par_reg[`P_CYL];
        3'd4:    res_byte = par_reg[`P_HEAD];
        3'd5:    res_byte = par_reg[`P_SEC];
        3'd6:    res_byte = par_reg[`P_SIZE];
        default: res_byte = 8'h00;
      endcase
    end else if (is_op(op_reg, `OP_FORMAT)) begin
      res_byte = (rcnt_reg == 3'd0) ? {5'h00, par_reg[`P_DRV][2:0]} : 8'h00; // RULE8
    end else begin
      res_byte = `INVALID_ST0; // RULE9
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= S_IDLE;
      op_reg        <= 8'h00;
      npar_reg      <= 4'h0;
      pcnt_reg      <= 4'h0;
      nres_reg      <= 3'h0;
      rcnt_reg      <= 3'h0;
      bcnt_reg      <= 9'h000;
      sec_left_reg  <= 8'h00;
      fid_reg       <= 2'h0;
      pcn_reg       <= 8'h00;
      ncn_reg       <= 8'h00;
      st0_reg       <= 8'h00;
      spec_reg      <= 8'h00;
      cfg_reg       <= 8'h00;
      recal_reg     <= 1'b0;
      seek_pend_reg <= 1'b0;
      done_evt      <= 1'b0;
      step          <= 1'b0;
      step_dir      <= 1'b0;
      drive_sel     <= 2'h0;
      head_sel      <= 1'b0;
      wr_byte       <= 8'h00;
      wr_byte_valid <= 1'b0;
      for (i = 0; i < 8; i = i + 1) par_reg[i] <= 8'h00;
    end else begin
      done_evt      <= 1'b0;
      step          <= 1'b0;
      wr_byte_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (data_wr) begin
            op_reg   <= wdata;
            pcnt_reg <= 4'h0;
            npar_reg <= par_count(wdata);
            if (is_op(wdata, `OP_SENSE_INT)) begin
              nres_reg      <= `NRES_SENSE; // RULE7
              seek_pend_reg <= 1'b0;
              rcnt_reg      <= 3'h0;
              state_reg     <= S_RES;
            end else if (par_count(wdata) == 4'h0) begin
              nres_reg  <= `NRES_INVALID; // RULE9
              rcnt_reg  <= 3'h0;
              state_reg <= S_RES;
            end else begin
              state_reg <= S_PARAM;
            end
          end
        end
        S_PARAM: if (data_wr) begin
          par_reg[pcnt_reg[2:0]] <= wdata; // RULE1
          pcnt_reg <= pcnt_reg + 4'h1;
          if (pcnt_reg == 4'h0) begin
            drive_sel <= wdata[1:0];
            head_sel  <= wdata[2];
          end
          if (pcnt_reg + 4'h1 == npar_reg) begin
            rcnt_reg <= 3'h0;
            bcnt_reg <= 9'h000;
            fid_reg  <= 2'h0;
            if (is_write) begin
              nres_reg  <= `NRES_WRITE;
              state_reg <= S_DATA;
            end else if (is_op(op_reg, `OP_FORMAT)) begin
              sec_left_reg <= par_reg[`P_FSC];
              nres_reg     <= `NRES_WRITE;
              state_reg    <= S_FMT;
            end else if (is_op(op_reg, `OP_RECAL)) begin
              recal_reg <= 1'b1; // RULE4
              ncn_reg   <= 8'h00;
              step_dir  <= 1'b0;
              state_reg <= S_STEP;
            end else if (is_op(op_reg, `OP_SEEK)) begin
              recal_reg <= 1'b0; // RULE5
              ncn_reg   <= wdata;
              step_dir  <= (wdata > pcn_reg);
              state_reg <= S_STEP;
            end else begin
              if (is_op(op_reg, `OP_SPECIFY)) spec_reg <= par_reg[`P_SPEC0];
              else cfg_reg <= par_reg[`P_CFG1];
              state_reg <= S_IDLE;
            end
          end
        end
        S_DATA: if (data_wr) begin
          wr_byte       <= wdata; // RULE2
          wr_byte_valid <= 1'b1;
          bcnt_reg      <= bcnt_reg + 9'h001;
          if (bcnt_reg + 9'h001 == `SEC_BYTES) begin
            bcnt_reg <= 9'h000;
            if (par_reg[`P_SEC] >= par_reg[`P_EOT]) begin
              done_evt  <= 1'b1;
              state_reg <= S_RES;
            end else begin
              par_reg[`P_SEC] <= par_reg[`P_SEC] + 8'h01;
            end
          end
        end
        S_FMT: if (data_wr) begin
          wr_byte       <= wdata; // RULE8
          wr_byte_valid <= 1'b1;
          fid_reg       <= fid_reg + 2'h1;
          if (fid_reg == 2'h3) begin
            sec_left_reg <= sec_left_reg - 8'h01;
            if (sec_left_reg <= 8'h01) begin
              done_evt  <= 1'b1;
              state_reg <= S_RES;
            end
          end
        end
        S_STEP: begin
          if (recal_reg ? track0 : (pcn_reg == ncn_reg)) begin
            if (recal_reg) pcn_reg <= 8'h00;
            st0_reg       <= `ST0_SEEK_END | {6'h00, drive_sel};
            seek_pend_reg <= 1'b1;
            done_evt      <= 1'b1; // RULE4
            state_reg     <= S_IDLE;
          end else if (step_tick) begin
            step    <= 1'b1; // RULE5
            pcn_reg <= step_dir ? pcn_reg + 8'h01 : pcn_reg - 8'h01;
          end
        end
        S_RES: if (data_rd) begin
          rcnt_reg <= rcnt_reg + 3'h1;
          if (rcnt_reg + 3'h1 == nres_reg) state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // interrupt: bit0 command end, bit1 drive not ready during write data (not format); write one to clear, set wins
  wire [1:0] irq_set = {~drive_ready & (state_reg == S_DATA), done_evt};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr && addr == `IRQ_OFS) ? wdata[1:0] : 2'b00))
                      | irq_set;
      if (wr && addr == `MASK_OFS) irq_mask_reg <= wdata[1:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        `IRQ_OFS:  rdata <= {6'h00, irq_stat_reg};
        `MASK_OFS: rdata <= {6'h00, irq_mask_reg};
        `DATA_OFS: rdata <= (state_reg == S_RES) ? res_byte : 8'h00;
        `MSR_OFS:  rdata <= {seek_pend_reg, 4'h0, state_reg};
        `PCN_OFS:  rdata <= pcn_reg;
        `CFG_OFS:  rdata <= cfg_reg;
        default:   rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end
endmodule // diskette_command_sequencer

//--- dv/dsk_drive_model.sv
// behavioural diskette drive: head position and track zero sensor
`timescale 1ns/1ps
module dsk_drive_model #(
  parameter int START_CYL = 2
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic step,
  input  wire logic step_dir,
  output logic      track0,
  output logic      drive_ready
);
  int cyl_reg;
  // head moves one cylinder per step pulse, never below zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyl_reg <= START_CYL;
    end else if (step) begin
      cyl_reg <= step_dir ? cyl_reg + 1 : (cyl_reg > 0 ? cyl_reg - 1 : 0);
    end
  end
  assign track0      = (cyl_reg == 0);
  assign drive_ready = 1'b1;
endmodule // dsk_drive_model

//--- dv/dsk_seq_properties.sv
// port assertions for the diskette command sequencer
`timescale 1ns/1ps
`include "dsk_consts.vh"
module dsk_seq_properties (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       track0,
  input wire logic       step,
  input wire logic       step_dir,
  input wire logic [7:0] wr_byte,
  input wire logic       wr_byte_valid,
  input wire logic       write_gate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_unmapped_read: assert property (rd && addr > 4'h5 |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_step_spacing: assert property ($rose(step) |-> ##1 !step [*8])
    else $error("step pulses too close");
  a_wbyte_data: assert property (wr_byte_valid |-> $past(wr) && $past(addr) == `DATA_OFS
    && wr_byte == $past(wdata))
    else $error("drive byte not taken from host write");
  a_wbyte_gate: assert property (wr_byte_valid |-> $past(write_gate))
    else $error("drive byte outside write execution");
  a_step_no_write: assert property (step |-> !write_gate)
    else $error("step during write execution");
  a_outward_stop: assert property (step && !step_dir |-> !track0)
    else $error("outward step at track zero");
  a_mask_off: assert property (wr && addr == `MASK_OFS && wdata == 8'h00 |=> !irq)
    else $error("interrupt with all sources masked");
endmodule // dsk_seq_properties
bind diskette_command_sequencer dsk_seq_properties dsk_seq_properties_inst (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq(irq), .track0(track0), .step(step), .step_dir(step_dir), .wr_byte(wr_byte),
  .wr_byte_valid(wr_byte_valid), .write_gate(write_gate));

//--- dv/tb_diskette_command_sequencer.sv
// self-checking bench for the diskette command sequencer
`timescale 1ns/1ps
`include "dsk_consts.vh"
`define CHK(a, e) check(a, e)
module tb_diskette_command_sequencer;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, irq, track0, drive_ready, step, step_dir;
  logic head_sel, wr_byte_valid, write_gate;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, wr_byte;
  logic [1:0] drive_sel;
  int miscompares = 0, cmp_count = 0, nexp = 0, cycles = 0;
  always #5 clk = ~clk;
  diskette_command_sequencer diskette_command_sequencer_inst (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .track0(track0), .drive_ready(drive_ready), .step(step), .step_dir(step_dir),
    .drive_sel(drive_sel), .head_sel(head_sel), .wr_byte(wr_byte),
    .wr_byte_valid(wr_byte_valid), .write_gate(write_gate));
  dsk_drive_model dsk_drive_model_inst (.clk(clk), .arst_n(arst_n), .step(step),
    .step_dir(step_dir), .track0(track0), .drive_ready(drive_ready));
  task automatic check(input logic [7:0] a, input logic [7:0] e);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e);
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
    `CHK(irq, 1'b1);
  endtask
  task automatic sense(input logic [7:0] cyl);
    wreg(`DATA_OFS, `OP_SENSE_INT);
    rchk(`DATA_OFS, `ST0_SEEK_END | 8'h01);
    rchk(`DATA_OFS, cyl);
    wreg(`IRQ_OFS, 8'h01);
    #1 `CHK(irq, 1'b0);
  endtask
  // drive bytes must arrive in host order, one per data write
  always @(posedge clk) if (wr_byte_valid === 1'b1) begin
    `CHK(wr_byte, nexp[7:0]);
    nexp++;
  end
  always @(posedge clk) if (++cycles == 20000) begin
    miscompares++;
    finish_test();
  end
  initial begin
    logic [7:0] wpar[9] = '{`OP_WRITE, 8'h05, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01, 8'h1b, 8'hff};
    logic [7:0] wres[7] = '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h01, 8'h00};
    logic [7:0] fpar[6] = '{`OP_FORMAT, 8'h01, 8'h00, 8'h02, 8'h1b, 8'he5};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wreg(`MASK_OFS, 8'h01);
    wreg(`DATA_OFS, 8'h00);
    rchk(`DATA_OFS, `INVALID_ST0);
    rchk(`DATA_OFS, 8'h00);
    wreg(`DATA_OFS, `OP_RECAL);
    wreg(`DATA_OFS, 8'h01);
    wait_irq();
    sense(8'h00);
    wreg(`DATA_OFS, `OP_SEEK);
    wreg(`DATA_OFS, 8'h01);
    wreg(`DATA_OFS, 8'h03);
    wait_irq();
    sense(8'h03);
    rchk(`PCN_OFS, 8'h03);
    // plain write first, then write deleted; drive byte order keeps counting across both
    for (int k = 0; k < 2; k++) begin
      wpar[0] = k ? `OP_WRITE_DEL : `OP_WRITE;
      foreach (wpar[i]) wreg(`DATA_OFS, wpar[i]);
      `CHK({5'h00, head_sel, drive_sel}, 8'h05);
      for (int i = 0; i < 128; i++) wreg(`DATA_OFS, 8'(k * 128 + i));
      repeat (2) @(posedge clk);
      `CHK(nexp[7:0], 8'(k * 128 + 128));
      foreach (wres[i]) rchk(`DATA_OFS, wres[i]);
    end
    // two sectors of four id bytes each, so the sector count must come from its own byte
    foreach (fpar[i]) wreg(`DATA_OFS, fpar[i]);
    for (int i = 0; i < 8; i++) wreg(`DATA_OFS, i[7:0]);
    repeat (2) @(posedge clk);
    `CHK(nexp[7:0], 8'h08);
    for (int i = 0; i < 7; i++) rchk(`DATA_OFS, (i == 0) ? 8'h01 : 8'h00);
    wreg(`DATA_OFS, `OP_SPECIFY);
    wreg(`DATA_OFS, 8'h8f);
    wreg(`DATA_OFS, 8'h02);
    rchk(`DATA_OFS, 8'h00);
    rchk(`MSR_OFS, 8'h00);
    wreg(`DATA_OFS, `OP_CONFIGURE);
    wreg(`DATA_OFS, 8'h00);
    wreg(`DATA_OFS, 8'h5a);
    wreg(`DATA_OFS, 8'h10);
    rchk(`CFG_OFS, 8'h5a);
    rchk(4'h9, 8'h00);
    wreg(`MASK_OFS, 8'h00);
    finish_test();
  end
endmodule // tb_diskette_command_sequencer
